// ==== inc/cpu_bus_defines.vh ====
// What this block does
// - Hold request floats address and data buses.
// - Hold request sampled, synchronised inside the block.
// - Interrupt sampled in instruction's last cycle.
// - Four testable flags plus decimal adjust flag.
// - Six general registers, pairs, plus accumulator.
// - Sixteen-bit stack pointer into external memory.
// - Stack saves accumulator, flags, counter, registers.
// - Sixteen address lines, eight bidirectional data lines.
// - Sixteen-bit program counter covers 64K bytes.
// - 256 directly addressed I/O ports.
`ifndef CPU_BUS_DEFINES_VH
`define CPU_BUS_DEFINES_VH

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define RESET_MIN_CYCLES 3
`define PC_RESET 16'h0000
`define SP_RESET 16'h0000
`define FLAGS_RESET 8'h02
`define IR_RESET 8'h00

// ----------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------
`define FLAG_CY 0
`define FLAG_P 2
`define FLAG_AC 4
`define FLAG_Z 6
`define FLAG_S 7

// ----------------------------------------------------------------
// Register file index of the accumulator
// ----------------------------------------------------------------
`define REG_ACC 3'h7

// ----------------------------------------------------------------
// Machine cycle kinds
// ----------------------------------------------------------------
`define KIND_DONE 3'h0
`define KIND_MEMRD 3'h1
`define KIND_STKRD 3'h2
`define KIND_STKWR 3'h3
`define KIND_IORD 3'h4
`define KIND_IOWR 3'h5
`define KIND_FETCH 3'h6

// ----------------------------------------------------------------
// Opcodes with fixed codes
// ----------------------------------------------------------------
`define OP_ADI 8'hc6
`define OP_JMP 8'hc3
`define OP_LXISP 8'h31
`define OP_CALL 8'hcd
`define OP_RET 8'hc9
`define OP_IN 8'hdb
`define OP_OUT 8'hd3
`define OP_DAA 8'h27
`define OP_EI 8'hfb
`define OP_DI 8'hf3

`endif

// ==== rtl/cpu_bus_control.v ====
`timescale 1ns/1ns
`include "cpu_bus_defines.vh"

module cpu_bus_control (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Address bus
  output reg [15:0] addrOut,
  output reg addrOe,
  // Data bus, split into in, out and enable
  input wire [7:0] dataIn,
  output reg [7:0] dataOut,
  output reg dataOe,
  // Bus control and status
  output reg data_bus_input_strobe,
  output reg wrN,
  output reg syncPulse,
  output reg waitState,
  output reg statusFetch,
  output reg statusIo,
  output reg statusStack,
  output reg statusIntAck,
  input wire ready,
  // Bus hold
  input wire holdReq,
  output reg hold_acknowledge,
  // Interrupt
  input wire intReq,
  output reg irq_accept_enabled_flag
);

  // ----------------------------------------------------------------
  // Bus states, one-hot
  // ----------------------------------------------------------------
  localparam [6:0] ST_ADDR = 7'h01;
  localparam [6:0] ST_SECOND = 7'h02; // second_machine_state
  localparam [6:0] ST_STALL = 7'h04; // inserted_stall_state
  localparam [6:0] ST_THIRD = 7'h08; // third_machine_state
  localparam [6:0] ST_FOURTH = 7'h10;
  localparam [6:0] ST_FIFTH = 7'h20;
  localparam [6:0] ST_HOLD = 7'h40; // hold_stall_state

  reg [6:0] state_r; // Current bus state
  reg [6:0] state_nxt;
  reg [2:0] mc_r; // Machine cycle within instruction, 0 is fetch
  reg [15:0] pc_r; // Program counter
  reg [15:0] sp_r; // Stack pointer
  reg [7:0] ir_r; // Current opcode
  reg [7:0] flags_r; // Condition flags
  reg [7:0] tmpLo_r; // Low operand byte or port number
  reg [7:0] tmpHi_r; // High operand byte
  reg intMode_r; // Next fetch is an interrupt acknowledge
  reg holdMeta_r; // Hold synchroniser, first stage
  reg holdSync_r; // Hold synchroniser, second stage
  reg holdLatch_r; // Hold seen in its sampling window

  // ----------------------------------------------------------------
  // Cycle plan per opcode
  // ----------------------------------------------------------------
  function [2:0] cycleKind;
    input [7:0] op;
    input [2:0] mc;
    begin
      cycleKind = `KIND_DONE;
      if (mc == 3'd0) begin
        cycleKind = `KIND_FETCH;
      end else begin
        casez (op)
          8'b00???110: if (mc == 3'd1 && op[5:3] != 3'h6) cycleKind = `KIND_MEMRD;
          `OP_ADI: if (mc == 3'd1) cycleKind = `KIND_MEMRD;
          `OP_JMP, `OP_LXISP: if (mc <= 3'd2) cycleKind = `KIND_MEMRD;
          `OP_CALL: begin
            if (mc <= 3'd2) cycleKind = `KIND_MEMRD;
            else if (mc <= 3'd4) cycleKind = `KIND_STKWR;
          end
          `OP_RET, 8'b11??0001: if (mc <= 3'd2) cycleKind = `KIND_STKRD;
          8'b11??0101, 8'b11???111: if (mc <= 3'd2) cycleKind = `KIND_STKWR;
          `OP_IN: begin
            if (mc == 3'd1) cycleKind = `KIND_MEMRD;
            else if (mc == 3'd2) cycleKind = `KIND_IORD;
          end
          `OP_OUT: begin
            if (mc == 3'd1) cycleKind = `KIND_MEMRD;
            else if (mc == 3'd2) cycleKind = `KIND_IOWR;
          end
          default: cycleKind = `KIND_DONE;
        endcase
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire [2:0] mcInc = mc_r + 3'd1; // Following machine cycle
  wire [2:0] kindNow = cycleKind(ir_r, mc_r);
  wire lastCycle = (cycleKind(ir_r, mcInc) == `KIND_DONE);
  wire [1:0] rp = ir_r[5:4]; // Register pair select
  wire isPush = (ir_r[7:6] == 2'b11) && (ir_r[3:0] == 4'h5);
  wire isPop = (ir_r[7:6] == 2'b11) && (ir_r[3:0] == 4'h1);
  wire isMvi = (ir_r[7:6] == 2'b00) && (ir_r[2:0] == 3'h6) && (ir_r[5:3] != 3'h6);
  wire isAdd = (ir_r[7:3] == 5'b10000) && (ir_r[2:0] != 3'h6);
  wire isMov = (ir_r[7:6] == 2'b01) && (ir_r[5:3] != 3'h6) && (ir_r[2:0] != 3'h6);
  wire isDaa = (ir_r == `OP_DAA);
  wire isRead = (kindNow == `KIND_FETCH) || (kindNow == `KIND_MEMRD) ||
                (kindNow == `KIND_STKRD) || (kindNow == `KIND_IORD);
  wire isWrite = (kindNow == `KIND_STKWR) || (kindNow == `KIND_IOWR);
  wire inWindow = (state_r == ST_SECOND) || (state_r == ST_STALL);
  wire endCycle = ((state_r == ST_THIRD) && (kindNow != `KIND_FETCH)) || (state_r == ST_FIFTH);
  wire hiPhase = (ir_r == `OP_CALL) ? (mc_r == 3'd3) : (mc_r == 3'd1);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  wire [7:0] rfA; // Accumulator, or high half of a pushed pair
  wire [7:0] rfB; // Source register, or low half of a pushed pair
  wire [2:0] rdAddrA = (isPush && rp != 2'b11) ? {rp, 1'b0} : `REG_ACC;
  wire [2:0] rdAddrB = isPush ? {rp, 1'b1} : ir_r[2:0];
  reg wrEn;
  reg [2:0] wrAddr;
  reg [7:0] wrData;

  cpu_reg_file u_regs (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .rdAddrA(rdAddrA),
    .rdAddrB(rdAddrB),
    .rdDataA(rfA),
    .rdDataB(rfB)
  );

  // ----------------------------------------------------------------
  // Adder with flags and decimal adjust
  // ----------------------------------------------------------------
  reg [7:0] aluB;
  reg [8:0] sum;
  reg [4:0] half;
  reg [7:0] aluFlags;
  // Decimal adjust reuses the adder with a 06/60 correction operand
  always @* begin
    aluB = (state_r == ST_FIFTH) ? rfB : dataIn;
    if (isDaa) begin
      aluB = 8'h00;
      if (rfA[3:0] > 4'h9 || flags_r[`FLAG_AC]) aluB = aluB | 8'h06;
      if (rfA[7:4] > 4'h9 || flags_r[`FLAG_CY] || (rfA[7:4] >= 4'h9 && rfA[3:0] > 4'h9))
        aluB = aluB | 8'h60;
    end
    sum = {1'b0, rfA} + {1'b0, aluB};
    half = {1'b0, rfA[3:0]} + {1'b0, aluB[3:0]};
    aluFlags = `FLAGS_RESET;
    aluFlags[`FLAG_S] = sum[7];
    aluFlags[`FLAG_Z] = (sum[7:0] == 8'h00);
    aluFlags[`FLAG_AC] = half[4];
    aluFlags[`FLAG_P] = ~^sum[7:0];
    aluFlags[`FLAG_CY] = sum[8] | (isDaa & flags_r[`FLAG_CY]);
  end
  wire aluUpd = ((state_r == ST_THIRD) && (kindNow == `KIND_MEMRD) && (ir_r == `OP_ADI)) ||
                ((state_r == ST_FIFTH) && (isAdd || isDaa));

  // ----------------------------------------------------------------
  // Register file write select
  // ----------------------------------------------------------------
  always @* begin
    wrEn = 1'b0;
    wrAddr = `REG_ACC;
    wrData = dataIn;
    if (state_r == ST_THIRD) begin
      if (kindNow == `KIND_MEMRD && isMvi) begin
        wrEn = 1'b1;
        wrAddr = ir_r[5:3];
      end else if (kindNow == `KIND_MEMRD && ir_r == `OP_ADI) begin
        wrEn = 1'b1;
        wrData = sum[7:0];
      end else if (kindNow == `KIND_STKRD && isPop) begin
        // Flags of a popped status word go to the flag register instead
        wrEn = !(rp == 2'b11 && mc_r == 3'd1);
        wrAddr = (rp == 2'b11) ? `REG_ACC : {rp, (mc_r == 3'd1)};
      end else if (kindNow == `KIND_IORD) begin
        wrEn = 1'b1;
      end
    end else if (state_r == ST_FIFTH) begin
      if (isAdd || isDaa) begin
        wrEn = 1'b1;
        wrData = sum[7:0];
      end else if (isMov) begin
        wrEn = 1'b1;
        wrAddr = ir_r[5:3];
        wrData = rfB;
      end
    end
  end

  // ----------------------------------------------------------------
  // Address and write data for the coming cycle
  // ----------------------------------------------------------------
  reg [15:0] addrCalc;
  reg [7:0] dataCalc;
  always @* begin
    case (kindNow)
      `KIND_STKWR: addrCalc = sp_r - 16'h0001;
      `KIND_STKRD: addrCalc = sp_r;
      `KIND_IORD, `KIND_IOWR: addrCalc = {tmpLo_r, tmpLo_r};
      default: addrCalc = pc_r;
    endcase
    if (kindNow == `KIND_IOWR) dataCalc = rfA;
    else if (isPush) dataCalc = hiPhase ? rfA : ((rp == 2'b11) ? flags_r : rfB);
    else dataCalc = hiPhase ? pc_r[15:8] : pc_r[7:0];
  end

  // ----------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------
  // Ready is used as is; outside logic keeps it clean and in step
  always @* begin
    case (state_r)
      ST_ADDR: state_nxt = ST_SECOND;
      ST_SECOND, ST_STALL: state_nxt = ready ? ST_THIRD : ST_STALL;
      ST_THIRD: state_nxt = (kindNow == `KIND_FETCH) ? ST_FOURTH : (holdLatch_r ? ST_HOLD : ST_ADDR);
      ST_FOURTH: state_nxt = ST_FIFTH;
      ST_FIFTH: state_nxt = holdLatch_r ? ST_HOLD : ST_ADDR;
      ST_HOLD: state_nxt = holdSync_r ? ST_HOLD : ST_ADDR;
      default: state_nxt = ST_ADDR;
    endcase
  end

  // ----------------------------------------------------------------
  // Core registers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_ADDR;
      mc_r <= 3'd0;
      pc_r <= `PC_RESET;
      sp_r <= `SP_RESET;
      ir_r <= `IR_RESET;
      flags_r <= `FLAGS_RESET;
      tmpLo_r <= 8'h00;
      tmpHi_r <= 8'h00;
      intMode_r <= 1'b0;
      irq_accept_enabled_flag <= 1'b0;
      holdMeta_r <= 1'b0;
      holdSync_r <= 1'b0;
      holdLatch_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      holdMeta_r <= holdReq;
      holdSync_r <= holdMeta_r;
      // Hold only counts when seen in its window, or while already held
      if (inWindow) holdLatch_r <= holdSync_r;
      else if (state_r == ST_HOLD && !holdSync_r) holdLatch_r <= 1'b0;
      if (aluUpd) flags_r <= aluFlags;
      if (state_r == ST_THIRD) begin
        case (kindNow)
          `KIND_FETCH: begin
            ir_r <= dataIn;
            intMode_r <= 1'b0;
            // The acknowledge fetch leaves the counter on the interrupted opcode
            if (!intMode_r) pc_r <= pc_r + 16'h0001;
          end
          `KIND_MEMRD: begin
            pc_r <= pc_r + 16'h0001;
            if (mc_r == 3'd1) tmpLo_r <= dataIn;
            if (mc_r == 3'd2) tmpHi_r <= dataIn;
            if (mc_r == 3'd2 && ir_r == `OP_JMP) pc_r <= {dataIn, tmpLo_r};
            if (mc_r == 3'd2 && ir_r == `OP_LXISP) sp_r <= {dataIn, tmpLo_r};
          end
          `KIND_STKRD: begin
            sp_r <= sp_r + 16'h0001;
            if (mc_r == 3'd1) tmpLo_r <= dataIn;
            if (mc_r == 3'd1 && isPop && rp == 2'b11) flags_r <= dataIn;
            if (mc_r == 3'd2 && ir_r == `OP_RET) pc_r <= {dataIn, tmpLo_r};
          end
          `KIND_STKWR: begin
            sp_r <= sp_r - 16'h0001;
            if (mc_r == 3'd4) pc_r <= {tmpHi_r, tmpLo_r};
            if (mc_r == 3'd2 && ir_r[2:0] == 3'h7) pc_r <= {10'h000, ir_r[5:3], 3'h0};
          end
          default: pc_r <= pc_r;
        endcase
      end
      if (state_r == ST_FIFTH && ir_r == `OP_EI) irq_accept_enabled_flag <= 1'b1;
      if (state_r == ST_FIFTH && ir_r == `OP_DI) irq_accept_enabled_flag <= 1'b0;
      if (endCycle) begin
        mc_r <= lastCycle ? 3'd0 : mcInc;
        // Interrupt is looked at only as an instruction finishes
        if (lastCycle && intReq && irq_accept_enabled_flag) begin
          intMode_r <= 1'b1;
          irq_accept_enabled_flag <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered pin outputs
  // ----------------------------------------------------------------
  // Every pin is a flop; address and status appear one cycle after the address state
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addrOut <= 16'h0000;
      addrOe <= 1'b0;
      dataOut <= 8'h00;
      dataOe <= 1'b0;
      data_bus_input_strobe <= 1'b0;
      wrN <= 1'b1;
      syncPulse <= 1'b0;
      waitState <= 1'b0;
      statusFetch <= 1'b0;
      statusIo <= 1'b0;
      statusStack <= 1'b0;
      statusIntAck <= 1'b0;
      hold_acknowledge <= 1'b0;
    end else begin
      if (state_r == ST_ADDR) begin
        addrOut <= addrCalc;
        dataOut <= dataCalc;
        statusFetch <= (kindNow == `KIND_FETCH);
        statusIo <= (kindNow == `KIND_IORD) || (kindNow == `KIND_IOWR);
        statusStack <= (kindNow == `KIND_STKRD) || (kindNow == `KIND_STKWR);
        statusIntAck <= (kindNow == `KIND_FETCH) && intMode_r;
      end
      syncPulse <= (state_r == ST_ADDR);
      waitState <= (state_nxt == ST_STALL);
      // Strobe covers the stall states and the third state of a read
      data_bus_input_strobe <= isRead && inWindow;
      wrN <= !(isWrite && inWindow);
      dataOe <= isWrite && inWindow;
      addrOe <= (state_nxt != ST_HOLD);
      hold_acknowledge <= (state_nxt == ST_HOLD);
    end
  end

endmodule

// ==== rtl/cpu_reg_file.v ====
`timescale 1ns/1ns
`include "cpu_bus_defines.vh"

module cpu_reg_file (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Write port
  input wire wrEn,
  input wire [2:0] wrAddr,
  input wire [7:0] wrData,
  // Registered read ports
  input wire [2:0] rdAddrA,
  input wire [2:0] rdAddrB,
  output reg [7:0] rdDataA,
  output reg [7:0] rdDataB
);

  // ----------------------------------------------------------------
  // Storage rows: B C D E H L, spare, accumulator
  // ----------------------------------------------------------------
  wire [63:0] rowFlat; // All rows side by side for the read muxes

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : row
      reg [7:0] cell_r; // One 8-bit working register
      // Each row loads only when its own index is written
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cell_r <= 8'h00;
        end else if (wrEn && (wrAddr == gi)) begin
          cell_r <= wrData;
        end
      end
      assign rowFlat[gi*8 +: 8] = cell_r;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data registers
  // ----------------------------------------------------------------
  // Registered reads keep the memory timing simple; callers wait a cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdDataA <= 8'h00;
      rdDataB <= 8'h00;
    end else begin
      rdDataA <= rowFlat[rdAddrA*8 +: 8];
      rdDataB <= rowFlat[rdAddrB*8 +: 8];
    end
  end

endmodule

// ==== test/cpu_bus_control_asserts.sv ====
`timescale 1ns/1ns
module cpu_bus_checker (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Bus pins
  input logic [15:0] addrOut,
  input logic addrOe,
  input logic dataOe,
  input logic data_bus_input_strobe,
  input logic wrN,
  input logic syncPulse,
  input logic waitState,
  input logic statusIo,
  input logic statusIntAck,
  input logic ready,
  // Hold and interrupt
  input logic holdReq,
  input logic hold_acknowledge,
  input logic intReq
);
  // ----------------------------------------
  // One domain, so one clock and one reset
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  hold_float_a: assert property (hold_acknowledge |-> !addrOe && !dataOe)
    else $error("buses driven while hold granted");
  hold_release_a: assert property (hold_acknowledge && !holdReq |-> ##[1:6] !hold_acknowledge)
    else $error("hold grant kept after request dropped");
  hold_cause_a: assert property ($rose(hold_acknowledge) |-> $past(holdReq, 2))
    else $error("hold granted without a request");
  // A read strobe and a driven data bus would fight on the wire
  strobe_quiet_a: assert property (data_bus_input_strobe |-> wrN && !dataOe)
    else $error("device drives data during read strobe");
  write_drive_a: assert property (!wrN |-> dataOe && addrOe)
    else $error("write strobe without driven buses");
  sync_single_a: assert property (syncPulse |=> !syncPulse)
    else $error("sync pulse longer than one cycle");
  stall_cause_a: assert property ($rose(waitState) |-> !$past(ready))
    else $error("stall inserted while ready high");
  stall_end_a: assert property (waitState && ready |-> ##[1:2] !waitState)
    else $error("stall kept after ready high");
  io_mirror_a: assert property (statusIo && addrOe |-> addrOut[15:8] == addrOut[7:0])
    else $error("port number not mirrored on address");
  // Request is taken at the edge ending the last cycle, one edge before the status shows
  ack_cause_a: assert property ($rose(statusIntAck) |-> $past(intReq, 2))
    else $error("interrupt acknowledged without request");

  // Main scenarios seen at least once
  hold_c: cover property ($rose(hold_acknowledge));
  stall_c: cover property ($rose(waitState));
  ack_c: cover property ($rose(statusIntAck));
endmodule

bind cpu_bus_control cpu_bus_checker chk_u (
  .clk(clk), .rst_n(rst_n), .addrOut(addrOut), .addrOe(addrOe), .dataOe(dataOe),
  .data_bus_input_strobe(data_bus_input_strobe), .wrN(wrN), .syncPulse(syncPulse),
  .waitState(waitState), .statusIo(statusIo), .statusIntAck(statusIntAck), .ready(ready),
  .holdReq(holdReq), .hold_acknowledge(hold_acknowledge), .intReq(intReq)
);

// ==== test/cpu_bus_control_bench.sv ====
`timescale 1ns/1ns
module cpu_bus_control_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic holdReq = 1'b0; // Bus request from a second master
  logic intReq = 1'b0; // Interrupt line
  logic slow = 1'b0; // Memory answers with stalls
  logic ready;
  logic [7:0] dataIn;
  logic [15:0] addrOut;
  logic [7:0] dataOut;
  logic addrOe, dataOe, strobe, wrN, syncPulse, waitState;
  logic statusFetch, statusIo, statusStack, statusIntAck, holdAck, irqEn;
  int errTotal = 0;
  int nTests = 0;
  int nWait = 0; // Stall cycles seen

  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (waitState === 1'b1) nWait <= nWait + 1;
  end

  cpu_bus_control dut_u (
    .clk(clk), .rst_n(rst_n), .addrOut(addrOut), .addrOe(addrOe), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe(dataOe), .data_bus_input_strobe(strobe), .wrN(wrN),
    .syncPulse(syncPulse), .waitState(waitState), .statusFetch(statusFetch), .statusIo(statusIo),
    .statusStack(statusStack), .statusIntAck(statusIntAck), .ready(ready), .holdReq(holdReq),
    .hold_acknowledge(holdAck), .intReq(intReq), .irq_accept_enabled_flag(irqEn)
  );
  cpu_mem_model partner_u (
    .clk(clk), .addrOut(addrOut), .dataOut(dataOut), .wrN(wrN), .strobe(strobe),
    .statusIo(statusIo), .statusStack(statusStack), .statusIntAck(statusIntAck), .waitState(waitState),
    .syncPulse(syncPulse), .slow(slow), .dataIn(dataIn), .ready(ready)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    nTests++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      errTotal++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic completeRun;
    $display("Comparisons %0d, mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset for the minimum three cycles, then the call, return and port write
  task automatic run_program(input logic s);
    int c0;
    int i;
    cyc(1);
    slow = s;
    partner_u.mem[8'hfe] = 8'h00;
    partner_u.mem[8'hfd] = 8'h00;
    rst_n = 1'b0;
    cyc(3);
    check("addrOe in reset", 16'h0, {15'h0, addrOe});
    check("wrN in reset", 16'h1, {15'h0, wrN});
    c0 = partner_u.ioCnt;
    nWait = 0;
    rst_n = 1'b1;
    for (i = 0; i < 6 && syncPulse !== 1'b1; i++) cyc(1);
    check("first fetch address", 16'h0000, addrOut);
    check("first fetch status", 16'h1, {15'h0, statusFetch});
    for (i = 0; i < 600 && partner_u.ioCnt == c0; i++) cyc(1);
    cyc(4);
    check("port write seen", 16'h1, {15'h0, partner_u.ioCnt != c0});
    check("port address", 16'h5555, partner_u.ioAddr);
    check("port data", 16'h006c, {8'h00, partner_u.ioData});
    check("pushed pair high", 16'h0015, {8'h00, partner_u.mem[8'hfd]});
    check("stack high byte", 16'h0000, {8'h00, partner_u.mem[8'hff]});
    check("stack low byte", 16'h0006, {8'h00, partner_u.mem[8'hfe]});
    check("stalls taken", {15'h0, s}, {15'h0, nWait > 0});
  endtask

  // A second master takes the buses, then gives them back
  task automatic hold_test;
    int i;
    holdReq = 1'b1;
    for (i = 0; i < 40 && holdAck !== 1'b1; i++) cyc(1);
    check("hold grant", 16'h1, {15'h0, holdAck});
    cyc(10);
    check("address floated", 16'h0, {15'h0, addrOe});
    check("data floated", 16'h0, {15'h0, dataOe});
    holdReq = 1'b0;
    for (i = 0; i < 10 && holdAck !== 1'b0; i++) cyc(1);
    check("hold released", 16'h0, {15'h0, holdAck});
    cyc(1);
    check("address driven again", 16'h1, {15'h0, addrOe});
  endtask

  // Interrupt in the spin loop; handler disables and returns
  task automatic irq_test;
    int i;
    for (i = 0; i < 100 && irqEn !== 1'b1; i++) cyc(1);
    check("interrupts enabled", 16'h1, {15'h0, irqEn});
    intReq = 1'b1;
    for (i = 0; i < 60 && statusIntAck !== 1'b1; i++) cyc(1);
    check("acknowledge cycle", 16'h1, {15'h0, statusIntAck});
    intReq = 1'b0;
    cyc(100);
    check("pushed return low", 16'h0009, {8'h00, partner_u.mem[8'hfe]});
    check("pushed return high", 16'h0000, {8'h00, partner_u.mem[8'hff]});
    check("handler disabled", 16'h0, {15'h0, irqEn});
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    run_program(1'b0);
    hold_test();
    irq_test();
    run_program(1'b1);
    completeRun();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    #(50 * 8000);
    errTotal++;
    completeRun();
  end
endmodule

// ==== test/cpu_mem_model.sv ====
`timescale 1ns/1ns
module cpu_mem_model (
  // Clock
  input logic clk,
  // Bus from the processor
  input logic [15:0] addrOut,
  input logic [7:0] dataOut,
  input logic wrN,
  input logic strobe,
  input logic statusIo,
  input logic statusStack,
  input logic statusIntAck,
  input logic waitState,
  input logic syncPulse,
  // Pace chosen by the bench
  input logic slow,
  // Answers
  output logic [7:0] dataIn,
  output logic ready
);
  logic [7:0] mem [0:255]; // Low page only, address wraps
  logic [7:0] lastVal = 8'h00; // Last byte put on the bus
  logic [1:0] waitCnt = 2'h0; // Stalls seen in this cycle
  logic [15:0] ioAddr = 16'h0000; // Last port address written
  logic [7:0] ioData = 8'h00; // Last port byte written
  int ioCnt = 0; // Port writes seen

  // ----------------------------------------
  // Program: set stack, call, port write, enable, spin
  // ----------------------------------------
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    {mem[0], mem[1], mem[2]} = {8'h31, 8'h00, 8'h01};
    {mem[3], mem[4], mem[5]} = {8'hcd, 8'h20, 8'h00};
    {mem[6], mem[7], mem[8]} = {8'hd3, 8'h55, 8'hfb};
    {mem[9], mem[10], mem[11]} = {8'hc3, 8'h09, 8'h00};
    {mem[16], mem[17]} = {8'hf3, 8'hc9}; // Handler disables, then returns
    // Subroutine: load B, read port, add, adjust, push B, pop D, add, moves, add, return
    // Acc runs 27, 3c, 42, 57, then 15 plus 57 gives 6c for the port write
    {mem[32], mem[33], mem[34], mem[35]} = {8'h06, 8'h15, 8'hdb, 8'h55};
    {mem[36], mem[37], mem[38], mem[39]} = {8'h80, 8'h27, 8'hc5, 8'hd1};
    {mem[40], mem[41], mem[42], mem[43], mem[44]} = {8'h82, 8'h5f, 8'h7a, 8'h83, 8'hc9};
    mem[85] = 8'h27; // Byte that port 55 answers with
  end

  // Data only inside the strobe; outside it a changing pattern, so stale data never passes
  always @* begin
    if (strobe) begin
      dataIn = statusIntAck ? 8'hd7 : mem[addrOut[7:0]];
    end else begin
      dataIn = ~lastVal;
    end
  end
  always @(posedge clk) begin
    lastVal <= dataIn;
  end

  // Slow mode asks for two stalls; ready moves only at the falling edge
  always @(negedge clk) begin
    if (syncPulse) begin
      waitCnt <= 2'h0;
    end else if (waitState && waitCnt != 2'h3) begin
      waitCnt <= waitCnt + 2'h1;
    end
  end
  assign ready = !slow || waitCnt >= 2'h2;

  // Writes land while the write strobe is low
  always @(negedge clk) begin
    if (!wrN && statusIo) begin
      ioAddr <= addrOut;
      ioData <= dataOut;
    end else if (!wrN && statusStack) begin
      // Only stack writes exist here, so a write without stack status is lost
      mem[addrOut[7:0]] <= dataOut;
    end
  end
  always @(negedge wrN) begin
    if (statusIo) begin
      ioCnt <= ioCnt + 1;
    end
  end
endmodule
